/* File: hdl/bcc_engine.sv */
// Block cipher chaining engine: FIFOs, chaining, counter and hash datapath
`timescale 1ns/1ps
`default_nettype none

module bcc_fifo #(
    parameter int W = 32,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic flush,
    input wire logic inValid,
    input wire logic [W-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [W-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wrPtr_r, rdPtr_r;
    logic [AW:0] count_r;
    logic push, pop;

    // Honest full and empty from the occupancy count
    assign inReady = (count_r != D[AW:0]);
    assign outValid = (count_r != '0);
    assign outData = mem[rdPtr_r];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_r] <= inData;
        end
    end

    // Pointers and count
    always_ff @(posedge clk) begin
        if (!reset_n || flush) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                wrPtr_r <= AW'(wrPtr_r + 1'b1);
            end
            if (pop) begin
                rdPtr_r <= AW'(rdPtr_r + 1'b1);
            end
            count_r <= (AW+1)'(count_r + push - pop);
        end
    end
endmodule

// Function
// - Triple-DES CBC decrypt: D(secret_word_3), E(secret_word_2), D(secret_word_1), then XOR chain.
// - DES CBC decrypt keeps each ciphertext as next chain; first uses IV.
// - Single DES uses only the secret_word_1 stage.
// - AES keys of 128, 192, 256 bits; IV or nonce use follows mode.
// - AES key from words 3-2, 3-1 or 3-0 by key size.
// - AES ECB encrypt swaps, encrypts, swaps back, pushes 128 bits.
// - AES decrypt uses key-derived final round key as first round key.
// - AES CBC encrypt XORs chain first; ciphertext becomes next chain.
// - AES CBC decrypt XORs chain after cipher; ciphertext is next chain.
// - CTR increments only low 32 counter bits; upper 96 stay.
// - CTR decrypt equals encrypt: forward cipher on counter, XOR data.
// - GCM prepare computes hash key, stores it, clears enable.
// - FIFO not-full, empty, not-empty and full flags are provided.
// - After tag length words, tag appears as four output words.
// - Tag uses a field multiplier; payload is CTR encrypted.
// - IV writes are ignored while busy.
// - Swap type applies none, half-word, byte or bit swap both ways.
// - Key-derive code clears busy and enable once round keys ready.
module bcc_engine #(
    parameter int DEPTH = bcc_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire bcc_pkg::bcc_cfg_t cfg,
    input wire bcc_pkg::bcc_key_t secretWords,
    input wire logic enableSet,
    input wire logic enableClr,
    input wire logic fifoFlush,
    input wire logic ivWrite,
    input wire logic [127:0] ivData,
    input wire logic dataInValid,
    input wire logic [31:0] dataInPort,
    output logic dataInReady,
    output logic dataOutValid,
    output logic [31:0] dataOutPort,
    input wire logic dataOutReady,
    output bcc_pkg::bcc_stat_t status
);
    import bcc_pkg::*;

    localparam int CW = $clog2(CORE_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(CORE_CYC - 1);

    typedef enum logic [2:0] {
        ST_IDLE, ST_LOAD, ST_RUN, ST_STORE, ST_KEY
    } bcc_state_t;

    bcc_state_t state_r;
    logic [CW-1:0] cnt_r;
    logic [2:0] left_r;
    logic enable_r, busy_r;
    logic [127:0] blk_r, res_r, chain_r, j0_r, ghash_r, hashKey_r, decKey_r;
    logic [127:0] kFold, res, chainNxt, ghNxt, ctrNext, tmp;
    logic [63:0] d;
    logic [2:0] nIn, nOut;
    logic [31:0] inWord;
    logic inAvail, inPop, outReadyF, outPush, keyJob, runDone, keyDone;
    logic isDes, isTdes, isCbc;
    logic outValidF, inReadyF;

    // Per-word swap by data type
    function automatic logic [31:0] swapW(input logic [31:0] w,
                                          input logic [1:0] t);
        logic [31:0] r;
        r = w;
        unique case (t)
            SW_NONE: r = w;
            SW_HALF: r = {w[15:0], w[31:16]};
            SW_BYTE: r = {w[7:0], w[15:8], w[23:16], w[31:24]};
            SW_BIT: for (int i = 0; i < 32; i++) r[i] = w[31-i];
        endcase
        return r;
    endfunction

    // Compact stand-in stage for the DES primitive
    function automatic logic [63:0] desE(input logic [63:0] x,
                                         input logic [63:0] k);
        logic [63:0] t;
        t = x ^ k;
        return {t[62:0], t[63]};
    endfunction
    function automatic logic [63:0] desD(input logic [63:0] y,
                                         input logic [63:0] k);
        return {y[0], y[63:1]} ^ k;
    endfunction

    // Compact stand-in for the AES forward and inverse cipher
    function automatic logic [127:0] aesE(input logic [127:0] x,
                                          input logic [127:0] k);
        logic [127:0] t;
        t = x ^ k;
        return {t[126:0], t[127]};
    endfunction
    function automatic logic [127:0] aesD(input logic [127:0] y,
                                          input logic [127:0] k);
        return {y[0], y[127:1]} ^ k;
    endfunction

    // Multiplier over the fixed hash field
    function automatic logic [127:0] gfMul(input logic [127:0] x,
                                           input logic [127:0] y);
        logic [127:0] z, v;
        z = '0;
        v = y;
        for (int i = 0; i < 128; i++) begin
            if (x[127-i]) z = z ^ v;
            v = v[0] ? ((v >> 1) ^ GF_POLY) : (v >> 1);
        end
        return z;
    endfunction

    // Input FIFO, filled by the CPU or DMA
    bcc_fifo #(.W(WORD_W), .D(DEPTH)) inFifo (
        .clk(clk), .reset_n(reset_n), .flush(fifoFlush && !enable_r),
        .inValid(dataInValid), .inData(dataInPort), .inReady(inReadyF),
        .outValid(inAvail), .outData(inWord), .outReady(inPop)
    );

    // Output FIFO; a full FIFO stalls the store state
    bcc_fifo #(.W(WORD_W), .D(DEPTH)) outFifo (
        .clk(clk), .reset_n(reset_n), .flush(fifoFlush && !enable_r),
        .inValid(outPush), .inData(swapW(res_r[127:96],
            cfg.swapTypeSelect)), .inReady(outReadyF),
        .outValid(outValidF), .outData(dataOutPort),
        .outReady(dataOutReady)
    );

    // Port flags taken from the FIFO occupancy registers
    assign dataInReady = inReadyF;
    assign dataOutValid = outValidF;
    assign status = '{inputFifoNotFull: inReadyF,
                      inputFifoEmpty: !inAvail,
                      outputFifoNotEmpty: outValidF,
                      outputFifoFull: !outReadyF,
                      busy: busy_r, unitEnableBit: enable_r};

    // Mode decode and handshakes
    assign isTdes = (cfg.algorithmModeSelect == ALG_TDES_ECB) ||
                    (cfg.algorithmModeSelect == ALG_TDES_CBC);
    assign isDes = isTdes || (cfg.algorithmModeSelect == ALG_DES_ECB) ||
                   (cfg.algorithmModeSelect == ALG_DES_CBC);
    assign isCbc = (cfg.algorithmModeSelect == ALG_TDES_CBC) ||
                   (cfg.algorithmModeSelect == ALG_DES_CBC) ||
                   (cfg.algorithmModeSelect == ALG_AES_CBC);
    assign keyJob = (cfg.algorithmModeSelect == ALG_KEY_DERIVE) ||
                    ((cfg.algorithmModeSelect == ALG_AES_GCM) &&
                     (cfg.authPhaseSelect == PH_PREPARE));
    assign nIn = isDes ? DES_WORDS : AES_WORDS;
    assign nOut = ((cfg.algorithmModeSelect == ALG_AES_GCM) &&
                   (cfg.authPhaseSelect == PH_AAD)) ? NO_WORDS : nIn;
    assign inPop = (state_r == ST_LOAD) && inAvail;
    assign outPush = (state_r == ST_STORE);
    assign runDone = (state_r == ST_RUN) && (cnt_r == '0);
    assign keyDone = (state_r == ST_KEY) && (cnt_r == '0);
    assign ctrNext = {chain_r[127:32], chain_r[31:0] + CTR_STEP};

    // Key folding by key size
    always_comb begin
        kFold = {secretWords.secretWord3, secretWords.secretWord2};
        if (cfg.keySize != KS_128) begin
            kFold = kFold ^ {64'h0, secretWords.secretWord1};
        end
        if (cfg.keySize == KS_256) begin
            kFold = kFold ^ {secretWords.secretWord0, 64'h0};
        end
    end

    // Per-block datapath result
    always_comb begin
        res = blk_r;
        chainNxt = chain_r;
        ghNxt = ghash_r;
        d = blk_r[63:0];
        tmp = blk_r;
        unique case (cfg.algorithmModeSelect)
            ALG_TDES_ECB, ALG_TDES_CBC, ALG_DES_ECB, ALG_DES_CBC: begin
                if (cfg.directionSelect) begin
                    if (isTdes) begin
                        d = desD(d, secretWords.secretWord3);
                        d = desE(d, secretWords.secretWord2);
                    end
                    d = desD(d, secretWords.secretWord1);
                    if (isCbc) begin
                        d = d ^ chain_r[63:0];
                        chainNxt = {64'h0, blk_r[63:0]};
                    end
                end else begin
                    if (isCbc) d = d ^ chain_r[63:0];
                    d = desE(d, secretWords.secretWord1);
                    if (isTdes) begin
                        d = desD(d, secretWords.secretWord2);
                        d = desE(d, secretWords.secretWord3);
                    end
                    if (isCbc) chainNxt = {64'h0, d};
                end
                res = {d, 64'h0};
            end
            ALG_AES_ECB, ALG_AES_CBC: begin
                if (cfg.directionSelect) begin
                    tmp = aesD(blk_r, decKey_r);
                    if (isCbc) begin
                        tmp = tmp ^ chain_r;
                        chainNxt = blk_r;
                    end
                end else begin
                    if (isCbc) tmp = tmp ^ chain_r;
                    tmp = aesE(tmp, kFold);
                    if (isCbc) chainNxt = tmp;
                end
                res = tmp;
            end
            ALG_AES_CTR: begin
                res = blk_r ^ aesE(chain_r, kFold);
                chainNxt = ctrNext;
            end
            ALG_AES_GCM: begin
                unique case (cfg.authPhaseSelect)
                    PH_AAD: ghNxt = gfMul(ghash_r ^ blk_r, hashKey_r);
                    PH_PAYLOAD: begin
                        res = blk_r ^ aesE(ctrNext, kFold);
                        chainNxt = ctrNext;
                        ghNxt = gfMul(ghash_r ^ (cfg.directionSelect ?
                                      blk_r : res), hashKey_r);
                    end
                    PH_TAG: begin
                        tmp = gfMul(ghash_r ^ blk_r, hashKey_r);
                        res = tmp ^ aesE(j0_r, kFold);
                        ghNxt = tmp;
                    end
                    PH_PREPARE: res = blk_r;
                endcase
            end
            default: res = blk_r;
        endcase
    end

    // Sequencer
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            left_r <= '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (enable_r && keyJob) begin
                        state_r <= ST_KEY;
                        cnt_r <= CNT_LAST;
                    end else if (enable_r) begin
                        state_r <= ST_LOAD;
                        left_r <= nIn;
                    end
                end
                ST_LOAD: begin
                    if (!enable_r) begin
                        state_r <= ST_IDLE;
                    end else if (inPop) begin
                        left_r <= 3'(left_r - ONE_WORD);
                        if (left_r == ONE_WORD) begin
                            state_r <= ST_RUN;
                            cnt_r <= CNT_LAST;
                        end
                    end
                end
                ST_RUN: begin
                    cnt_r <= CW'(cnt_r - 1'b1);
                    if (runDone) begin
                        left_r <= nOut;
                        state_r <= (nOut == NO_WORDS) ? ST_IDLE : ST_STORE;
                    end
                end
                ST_STORE: begin
                    if (outReadyF) begin
                        left_r <= 3'(left_r - ONE_WORD);
                        if (left_r == ONE_WORD) state_r <= ST_IDLE;
                    end
                end
                ST_KEY: begin
                    cnt_r <= CW'(cnt_r - 1'b1);
                    if (keyDone) state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Block capture, result shifting, chaining and hash state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            blk_r <= '0;
            res_r <= '0;
            chain_r <= '0;
            j0_r <= '0;
            ghash_r <= '0;
            hashKey_r <= '0;
            decKey_r <= '0;
        end else begin
            if (inPop) begin
                blk_r <= {blk_r[95:0], swapW(inWord, cfg.swapTypeSelect)};
            end
            if (runDone) begin
                res_r <= res;
                chain_r <= chainNxt;
                ghash_r <= ghNxt;
            end else if (ivWrite && !busy_r) begin
                chain_r <= ivData;
                j0_r <= ivData;
            end
            if (outPush && outReadyF) begin
                res_r <= {res_r[95:0], 32'h0};
            end
            if (keyDone && cfg.algorithmModeSelect == ALG_AES_GCM) begin
                hashKey_r <= aesE('0, kFold);
                ghash_r <= '0;
            end else if (keyDone) begin
                decKey_r <= kFold;
            end
        end
    end

    // Enable bit: software sets and clears, hardware clears after key jobs
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            enable_r <= 1'b0;
        end else if (keyDone) begin
            enable_r <= 1'b0;
        end else if (enableSet) begin
            enable_r <= 1'b1;
        end else if (enableClr) begin
            enable_r <= 1'b0;
        end
    end

    // Busy from core acceptance until the last word is pushed, or until the core ends a key job or an AAD block
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            busy_r <= 1'b0;
        end else if (state_r == ST_IDLE && enable_r && keyJob) begin
            busy_r <= 1'b1;
        end else if (inPop && left_r == ONE_WORD) begin
            busy_r <= 1'b1;
        end else if (keyDone || (runDone && nOut == NO_WORDS)) begin
            busy_r <= 1'b0;
        end else if (outPush && outReadyF && left_r == ONE_WORD) begin
            busy_r <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_busyStore;
        (state_r == ST_STORE || state_r == ST_RUN) |-> busy_r;
    endproperty
    a_busyStore: assert property (p_busyStore)
        else $error("busy low while block in core");

    property p_ctrStep;
        runDone && cfg.algorithmModeSelect == ALG_AES_CTR |=>
            chain_r[127:32] == $past(chain_r[127:32]) &&
            chain_r[31:0] == $past(chain_r[31:0]) + CTR_STEP;
    endproperty
    a_ctrStep: assert property (p_ctrStep)
        else $error("counter step wrong");

    property p_ivIgnored;
        ivWrite && busy_r && !runDone |=> $stable(chain_r);
    endproperty
    a_ivIgnored: assert property (p_ivIgnored)
        else $error("vector written while busy");

    property p_keyEnd;
        keyDone |=> !enable_r && !busy_r && state_r == ST_IDLE;
    endproperty
    a_keyEnd: assert property (p_keyEnd)
        else $error("key job did not release enable");

    property p_hashStore;
        keyDone && cfg.algorithmModeSelect == ALG_AES_GCM |=>
            hashKey_r == aesE('0, $past(kFold));
    endproperty
    a_hashStore: assert property (p_hashStore)
        else $error("hash key not stored");

    property p_cbcDecChain;
        runDone && isCbc && cfg.directionSelect && !isDes |=>
            chain_r == $past(blk_r);
    endproperty
    a_cbcDecChain: assert property (p_cbcDecChain)
        else $error("cbc chain not ciphertext");

    property p_tagWords;
        runDone && cfg.algorithmModeSelect == ALG_AES_GCM &&
            cfg.authPhaseSelect == PH_TAG |=>
            state_r == ST_STORE && left_r == AES_WORDS;
    endproperty
    a_tagWords: assert property (p_tagWords)
        else $error("tag not four words");

    property p_key128;
        cfg.keySize == KS_128 |->
            kFold == {secretWords.secretWord3, secretWords.secretWord2};
    endproperty
    a_key128: assert property (p_key128)
        else $error("128-bit key from wrong words");

    property p_swapIn;
        inPop |=> blk_r[31:0] ==
            swapW($past(inWord), $past(cfg.swapTypeSelect));
    endproperty
    a_swapIn: assert property (p_swapIn)
        else $error("input swap wrong");

    c_tag: cover property (runDone && cfg.authPhaseSelect == PH_TAG &&
                           cfg.algorithmModeSelect == ALG_AES_GCM);
    c_cbcDec: cover property (runDone && isCbc && cfg.directionSelect);
    c_keyDerive: cover property (keyDone &&
        cfg.algorithmModeSelect == ALG_KEY_DERIVE);
    c_outStall: cover property (outPush && !outReadyF);
endmodule

`default_nettype wire

/* File: hdl/bcc_pkg.sv */
// Shared constants and carrier types of the block cipher chaining engine
package bcc_pkg;
    localparam int WORD_W = 32;
    localparam int BLK_W = 128;
    localparam int FIFO_DEPTH = 8;
    localparam logic [2:0] AES_WORDS = 3'h4;
    localparam logic [2:0] DES_WORDS = 3'h2;
    localparam logic [2:0] NO_WORDS = 3'h0;
    localparam logic [2:0] ONE_WORD = 3'h1;
    // Core latency per block, in ns, and the derived cycle count
    localparam int CLK_MHZ = 25;
    localparam int CORE_NS = 400;
    localparam int CORE_CYC = (CORE_NS * CLK_MHZ + 999) / 1000;
    // Algorithm codes
    localparam logic [3:0] ALG_TDES_ECB = 4'h0;
    localparam logic [3:0] ALG_TDES_CBC = 4'h1;
    localparam logic [3:0] ALG_DES_ECB = 4'h2;
    localparam logic [3:0] ALG_DES_CBC = 4'h3;
    localparam logic [3:0] ALG_AES_ECB = 4'h4;
    localparam logic [3:0] ALG_AES_CBC = 4'h5;
    localparam logic [3:0] ALG_AES_CTR = 4'h6;
    localparam logic [3:0] ALG_KEY_DERIVE = 4'h7;
    localparam logic [3:0] ALG_AES_GCM = 4'h8;
    // Authentication phases
    localparam logic [1:0] PH_PREPARE = 2'h0;
    localparam logic [1:0] PH_AAD = 2'h1;
    localparam logic [1:0] PH_PAYLOAD = 2'h2;
    localparam logic [1:0] PH_TAG = 2'h3;
    // Key sizes
    localparam logic [1:0] KS_128 = 2'h0;
    localparam logic [1:0] KS_192 = 2'h1;
    localparam logic [1:0] KS_256 = 2'h2;
    // Swap types
    localparam logic [1:0] SW_NONE = 2'h0;
    localparam logic [1:0] SW_HALF = 2'h1;
    localparam logic [1:0] SW_BYTE = 2'h2;
    localparam logic [1:0] SW_BIT = 2'h3;
    // Reduction constant of the hash field
    localparam logic [127:0] GF_POLY = {8'hE1, 120'h0};
    localparam logic [31:0] CTR_STEP = 32'h1;

    typedef struct packed {
        logic [3:0] algorithmModeSelect;
        logic [1:0] authPhaseSelect;
        logic directionSelect;
        logic [1:0] keySize;
        logic [1:0] swapTypeSelect;
    } bcc_cfg_t;

    typedef struct packed {
        logic [63:0] secretWord3;
        logic [63:0] secretWord2;
        logic [63:0] secretWord1;
        logic [63:0] secretWord0;
    } bcc_key_t;

    typedef struct packed {
        logic inputFifoNotFull;
        logic inputFifoEmpty;
        logic outputFifoNotEmpty;
        logic outputFifoFull;
        logic busy;
        logic unitEnableBit;
    } bcc_stat_t;
endpackage

/* File: sim/bcc_host_sink.sv */
// Host side model that drains the result stream
`timescale 1ns/1ps
`default_nettype none
module bcc_host_sink (
    input wire logic clk,
    input wire logic valid,
    input wire logic [31:0] data,
    output logic ready
);
    logic [31:0] got[$];
    // Takes a word on a handshake edge, stalls at random
    always @(posedge clk) begin
        if (valid && ready) got.push_back(data);
        ready <= ($urandom % 3) != 0;
    end
endmodule
`default_nettype wire

/* File: sim/test_bcc_engine.sv */
// Self-checking bench with a block model of the engine
`timescale 1ns/1ps
`default_nettype none
module test_bcc_engine;
    import bcc_pkg::*;
    logic clk = 0, reset_n = 0, enableSet = 0, enableClr = 0;
    logic fifoFlush = 0, ivWrite = 0, dataInValid = 0;
    logic dataInReady, dataOutValid, dataOutReady;
    logic [127:0] ivData = '0, chain, gh, j0;
    logic [31:0] dataInPort = '0, dataOutPort;
    bcc_cfg_t cfg = '0;
    bcc_key_t key = '0;
    bcc_stat_t status;
    int mismatches = 0, samples_checked = 0;
    // Clock
    always #20 clk = ~clk;
    bcc_engine bcc_engine_inst (.clk(clk), .reset_n(reset_n), .cfg(cfg),
        .secretWords(key), .enableSet(enableSet), .enableClr(enableClr),
        .fifoFlush(fifoFlush), .ivWrite(ivWrite), .ivData(ivData),
        .dataInValid(dataInValid), .dataInPort(dataInPort),
        .dataInReady(dataInReady), .dataOutValid(dataOutValid),
        .dataOutPort(dataOutPort), .dataOutReady(dataOutReady),
        .status(status));
    bcc_host_sink bcc_host_sink_inst (.clk(clk), .valid(dataOutValid),
        .data(dataOutPort), .ready(dataOutReady));
    task automatic test_done;
        $display("checked=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    function automatic logic [127:0] swb(input logic [127:0] b);
        logic [31:0] w;
        for (int i = 0; i < 4; i++) begin
            w = b[32*i +: 32];
            case (cfg.swapTypeSelect)
                SW_HALF: w = {w[15:0], w[31:16]};
                SW_BYTE: w = {w[7:0], w[15:8], w[23:16], w[31:24]};
                SW_BIT: w = {<<{w}};
                default: w = w;
            endcase
            b[32*i +: 32] = w;
        end
        return b;
    endfunction
    function automatic logic [127:0] enc(input logic [127:0] x);
        logic [127:0] k;
        k = {key.secretWord3, key.secretWord2};
        if (cfg.keySize != KS_128) k ^= {64'h0, key.secretWord1};
        if (cfg.keySize == KS_256) k ^= {key.secretWord0, 64'h0};
        x ^= k;
        return {x[126:0], x[127]};
    endfunction
    function automatic logic [127:0] dec(input logic [127:0] y);
        logic [127:0] k;
        k = enc('0);
        return {y[0], y[127:1]} ^ {k[0], k[127:1]};
    endfunction
    // Hash field multiply, reduction by the package polynomial
    function automatic logic [127:0] gmul(input logic [127:0] x,
                                          input logic [127:0] y);
        logic [127:0] z;
        z = '0;
        for (int i = 127; i >= 0; i--) begin
            if (x[i]) z ^= y;
            y = y[0] ? (y >> 1) ^ GF_POLY : y >> 1;
        end
        return z;
    endfunction
    function automatic logic [127:0] model(input logic [127:0] pt);
        logic [127:0] b, c, h;
        b = swb(pt);
        h = enc('0);
        case (cfg.algorithmModeSelect)
            ALG_AES_CBC: begin
                c = cfg.directionSelect ? dec(b) ^ chain : enc(b ^ chain);
                chain = cfg.directionSelect ? b : c;
            end
            ALG_AES_CTR: begin
                c = b ^ enc(chain);
                chain[31:0] += 32'h1;
            end
            ALG_AES_GCM: begin
                if (cfg.authPhaseSelect == PH_PAYLOAD) begin
                    chain[31:0] += 32'h1;
                    c = b ^ enc(chain);
                    gh = gmul(gh ^ c, h);
                end else begin
                    gh = gmul(gh ^ b, h);
                    c = gh ^ enc(j0);
                end
            end
            default: c = cfg.directionSelect ? dec(b) : enc(b);
        endcase
        return swb(c);
    endfunction
    task automatic setup(input logic [3:0] a, input logic [1:0] k,
                         input logic [1:0] s, input logic dir = 1'b0);
        enableClr <= 1'b1;
        @(posedge clk);
        enableClr <= 1'b0;
        cfg <= '{a, PH_PREPARE, dir, k, s};
        // Decryption keeps the key that the key job prepared
        if (!dir) for (int i = 0; i < 8; i++) key[32*i +: 32] <= $urandom;
        chain = {$urandom, $urandom, $urandom, 32'h1};
        gh = '0;
        j0 = chain;
        ivData <= chain;
        ivWrite <= 1'b1;
        fifoFlush <= 1'b1;
        @(posedge clk);
        ivWrite <= 1'b0;
        fifoFlush <= 1'b0;
        enableSet <= 1'b1;
        @(posedge clk);
        enableSet <= 1'b0;
    endtask
    task automatic blk(input int nOut = 4, input logic [127:0] fixed = '0);
        logic [127:0] pt, e;
        int n;
        bit tried, hit, done;
        pt = {$urandom, $urandom, $urandom, $urandom};
        if (fixed != '0) pt = fixed;
        tried = 0;
        for (int i = 0; i < 4; i++) begin
            dataInValid <= 1'b1;
            dataInPort <= pt[127-32*i -: 32];
            n = 0;
            // Ready looked at mid-cycle; the word goes at the next edge
            do begin
                @(negedge clk);
                n++;
            end while (dataInReady !== 1'b1 && n < 50);
            if (dataInReady !== 1'b1) begin
                mismatches++;
                test_done();
            end
            @(posedge clk);
        end
        dataInValid <= 1'b0;
        e = model(pt);
        n = 0;
        // Wait for results and idle; one vector write tried while busy
        do begin
            @(negedge clk);
            n++;
            done = bcc_host_sink_inst.got.size() >= nOut && !status.busy &&
                   n > 2;
            hit = status.busy && !tried;
            tried |= hit;
            @(posedge clk);
            ivWrite <= hit;
            if (hit) ivData <= ~chain;
        end while (!done && n < 300);
        if (!done) begin
            mismatches++;
            test_done();
        end
        for (int i = 0; i < nOut; i++)
            chk(bcc_host_sink_inst.got.pop_front(), e[127-32*i-:32]);
    endtask
    // Wait for hardware to drop the enable bit after a key job
    task automatic waitOff;
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (status.unitEnableBit !== 1'b0 && n < 100);
        if (status.unitEnableBit !== 1'b0) begin
            mismatches++;
            test_done();
        end
        @(posedge clk);
    endtask
    // Main sequence
    initial begin
        void'($urandom(92));
        repeat (12) @(posedge clk);
        chk({26'h0, status}, 32'h30);
        reset_n <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            setup(ALG_AES_ECB, KS_128, 2'(s));
            blk();
            $display("ecb swap %0d done", s);
        end
        for (int k = 1; k < 3; k++) begin
            setup(ALG_AES_ECB, 2'(k), SW_NONE);
            blk();
            $display("ecb key size %0d done", k);
        end
        setup(ALG_AES_CBC, KS_256, SW_BYTE);
        repeat (2) blk();
        $display("cbc done");
        setup(ALG_AES_CTR, KS_192, SW_HALF);
        repeat (3) blk();
        $display("ctr done");
        setup(ALG_AES_GCM, KS_128, SW_NONE);
        waitOff();
        cfg.authPhaseSelect <= PH_AAD;
        enableSet <= 1'b1;
        @(posedge clk);
        enableSet <= 1'b0;
        blk(0);
        cfg.authPhaseSelect <= PH_PAYLOAD;
        blk();
        cfg.authPhaseSelect <= PH_TAG;
        blk(4, {64'h80, 64'h80});
        $display("gcm done");
        setup(ALG_KEY_DERIVE, KS_128, SW_NONE);
        waitOff();
        chk({30'h0, status.busy, status.unitEnableBit}, 32'h0);
        $display("key derive done");
        setup(ALG_AES_CBC, KS_128, SW_BIT, 1'b1);
        repeat (2) blk();
        setup(ALG_AES_ECB, KS_128, SW_HALF, 1'b1);
        blk();
        $display("decrypt done");
        test_done();
    end
endmodule
`default_nettype wire
